// ---- rtl/clock_fail_monitor_pkg.sv ----
package clock_fail_monitor_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word each)
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFF_OSC_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] OFF_OSC_STAT = 8'h04;
  localparam logic [APB_AW-1:0] OFF_PFLAG2 = 8'h08;
  localparam logic [APB_AW-1:0] OFF_PEN2 = 8'h0c;
  localparam logic [APB_AW-1:0] OFF_IRQ_CTRL = 8'h10;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int IFS_LSB = 0;
  localparam int IFS_W = 4;
  localparam int SCS_LSB = 4;
  localparam int SCS_W = 2;
  localparam logic [IFS_W-1:0] IFS_RST = 4'h7;
  localparam logic [SCS_W-1:0] SCS_RST = 2'h0;
  localparam logic [SCS_W-1:0] SCS_SECONDARY = 2'h1;
  localparam int SCS_INT_BIT = 1;
  localparam int OSF_BIT = 7;
  localparam int OSE_BIT = 7;
  localparam int GIE_BIT = 7;
  localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
  localparam int ST_OST_DONE = 0;
  localparam int ST_EXT_RUN = 1;
  localparam int ST_FAIL_SAFE = 2;
  localparam int ST_MON_ON = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LF_DIV_RATIO = 64;
  localparam int OST_EXT_CYCLES = 1024;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OSC_LOW_POWER_CRYSTAL = 3'b000,
    OSC_CRYSTAL = 3'b001,
    OSC_HIGH_SPEED_CRYSTAL = 3'b010,
    OSC_EXTERNAL_CLOCK_INPUT = 3'b011,
    OSC_SECONDARY_TIMER = 3'b100,
    OSC_RESISTOR_CAPACITOR = 3'b101,
    OSC_INTERNAL = 3'b110
  } clock_fail_monitor_osc_mode_t;

  typedef enum logic [1:0] {
    CS_INT_START = 2'b00,
    CS_EXT_RUN = 2'b01,
    CS_FAIL_SAFE = 2'b10,
    CS_INT_RUN = 2'b11
  } clock_fail_monitor_clk_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } clock_fail_monitor_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } clock_fail_monitor_apb_rsp_t;

  typedef struct packed {
    logic sel_internal;
    logic sel_secondary;
    logic fail_safe;
    logic dual_speed;
    logic [IFS_W-1:0] int_freq_sel;
  } clock_fail_monitor_clk_ctrl_t;

endpackage

// ---- rtl/clock_fail_monitor_div.sv ----
`timescale 1ns/100ps
// divides the synchronised low-frequency oscillator into the sample clock
module clock_fail_monitor_div
  import clock_fail_monitor_pkg::*;
#(
  parameter int unsigned DIV = LF_DIV_RATIO
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic lf_rise,
  output logic samp_rise,
  output logic samp_fall
);

  localparam int unsigned HALF = DIV / 2;
  localparam int CW = $clog2(HALF);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic samp;
    logic rise;
    logic fall;
  } clock_fail_monitor_div_st_t;

  clock_fail_monitor_div_st_t q;
  clock_fail_monitor_div_st_t d;

  always_comb begin
    d = q;
    d.rise = 1'b0;
    d.fall = 1'b0;
    if (lf_rise) begin
      if (q.cnt == CW'(HALF - 1)) begin
        d.cnt = '0;
        d.samp = ~q.samp;
        d.rise = ~q.samp;
        d.fall = q.samp;
      end else begin
        d.cnt = q.cnt + CW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign samp_rise = q.rise;
  assign samp_fall = q.fall;

endmodule

// ---- rtl/clock_fail_monitor_ost.sv ----
`timescale 1ns/100ps
// oscillator start-up timer: counts falling edges of the external clock
module clock_fail_monitor_ost
  import clock_fail_monitor_pkg::*;
#(
  parameter int unsigned COUNT = OST_EXT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic bypass,
  input wire logic tick,
  output logic done
);

  localparam int CW = $clog2(COUNT + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic done;
  } clock_fail_monitor_ost_st_t;

  clock_fail_monitor_ost_st_t q;
  clock_fail_monitor_ost_st_t d;

  always_comb begin
    d = q;
    if (start) begin
      d.cnt = '0;
      d.done = bypass;
    end else if (!q.done && tick) begin
      d.cnt = q.cnt + CW'(1);
      d.done = (q.cnt == CW'(COUNT - 1));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done = q.done;

  chk_ost_bypass_start: assert property (@(posedge pclk) disable iff (!presetn)
    start |=> (done == $past(bypass)))
    else $error("start-up timer bypass not honoured");

endmodule

// ---- rtl/clock_fail_monitor_top.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// fail-safe clock monitor
// ----------------------------------------------------------------
// Overview of operation
// - no failure is reported before the start-up timer has expired.
// - monitoring runs only while the monitor enable fuse is set.
// - every external oscillator mode is monitored.
// - sample clock is the low-frequency internal oscillator divided by 64.
// - each falling edge of the external clock sets the fail-detect latch.
// - each rising edge of the sample clock clears the fail-detect latch, unless a falling external edge sets it in the same cycle.
// - latch still clear after a whole sample half period means failure.
// - on failure, switch to the internal oscillator and set the fail flag.
// - the fail flag requests an interrupt only with its enable bit set.
// - after failure stay on the internal oscillator until software reselects or sleep is entered.
// - fallback frequency comes from the four-bit internal frequency select field.
// - reset, sleep entry or a source select change clear the fail-safe state.
// - a source select change restarts the start-up timer; run internal meanwhile.
// - fail-safe clears as soon as the source select changes, before any switch to the external clock.
// - software clears the flag before switching back; persisting failure re-sets it.
// - the start-up timer runs after every reset and after waking from sleep.
// - external clock input and RC modes skip the start-up timer.
// - an enabled monitor also enables dual-speed start-up.
// - detection stays off during start-up; status shows start-up and switchover.
// - the fail flag sets regardless of any interrupt enable.
// - the interrupt also needs the peripheral and global enables.
module clock_fail_monitor_top
  import clock_fail_monitor_pkg::*;
#(
  parameter int unsigned OST_COUNT = OST_EXT_CYCLES,
  parameter int unsigned DIV = LF_DIV_RATIO
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire clock_fail_monitor_apb_req_t apb_req,
  output clock_fail_monitor_apb_rsp_t apb_rsp,
  input wire logic ext_clk_pin,
  input wire logic lf_osc_pin,
  input wire logic monitor_enable_fuse,
  input wire clock_fail_monitor_osc_mode_t osc_mode,
  input wire logic sleep_req,
  output clock_fail_monitor_clk_ctrl_t clk_ctrl,
  output logic osc_fail_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ext_s1;
    logic ext_s2;
    logic ext_s3;
    logic lf_s1;
    logic lf_s2;
    logic lf_s3;
    logic fdl;
    logic sleep_q;
    logic ost_go;
    logic [IFS_W-1:0] ifs;
    logic [SCS_W-1:0] clock_source_select;
    logic osf;
    logic ose;
    logic global_irq_enable;
    logic peripheral_irq_enable;
    clock_fail_monitor_clk_state_t cs;
    logic [31:0] prdata;
    logic sel_int;
    logic sel_sec;
    logic fail_safe;
    logic irq;
  } clock_fail_monitor_top_st_t;

  clock_fail_monitor_top_st_t q;
  clock_fail_monitor_top_st_t d;

  logic ext_fall;
  logic lf_rise;
  logic samp_rise;
  logic samp_fall;
  logic ost_done;
  logic ost_bypass;
  logic ext_mode;
  logic monitor_on;
  logic fail_det;
  logic sleep_entry;
  logic sleep_exit;
  logic setup;
  logic access;
  logic wr;
  logic mapped;
  logic wr_ctrl;
  logic wr_pf2;
  logic wr_pen2;
  logic wr_irqc;
  logic scs_chg;
  logic [SCS_W-1:0] scs_new;
  logic [31:0] rdata;

  function automatic logic is_reg(input logic [APB_AW-1:0] a, input logic [APB_AW-1:0] off);
    return a[APB_AW-1:2] == off[APB_AW-1:2];
  endfunction

  // ----------------------------------------------------------------
  // sample clock and start-up timer
  // ----------------------------------------------------------------
  clock_fail_monitor_div #(
    .DIV(DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .lf_rise(lf_rise),
    .samp_rise(samp_rise),
    .samp_fall(samp_fall)
  );

  clock_fail_monitor_ost #(
    .COUNT(OST_COUNT)
  ) u_ost (
    .pclk(pclk),
    .presetn(presetn),
    .start(q.ost_go),
    .bypass(ost_bypass),
    .tick(ext_fall),
    .done(ost_done)
  );

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  always_comb begin
    // clock pin edge detection reads only the second and third stages
    ext_fall = q.ext_s3 & ~q.ext_s2;
    lf_rise = q.lf_s2 & ~q.lf_s3;
    sleep_entry = sleep_req & ~q.sleep_q;
    sleep_exit = ~sleep_req & q.sleep_q;
    ost_bypass = (osc_mode == OSC_EXTERNAL_CLOCK_INPUT) ||
                 (osc_mode == OSC_RESISTOR_CAPACITOR);
    ext_mode = (osc_mode != OSC_INTERNAL);
    // detection is off until the timer has expired and the switch is made
    monitor_on = monitor_enable_fuse && ext_mode && ost_done &&
                 (q.cs == CS_EXT_RUN) && !q.sleep_q;
    fail_det = monitor_on && samp_fall && !q.fdl;

    setup = apb_req.psel && !apb_req.penable;
    access = apb_req.psel && apb_req.penable;
    wr = access && apb_req.pwrite;
    mapped = is_reg(apb_req.paddr, OFF_OSC_CTRL) || is_reg(apb_req.paddr, OFF_OSC_STAT) ||
             is_reg(apb_req.paddr, OFF_PFLAG2) || is_reg(apb_req.paddr, OFF_PEN2) ||
             is_reg(apb_req.paddr, OFF_IRQ_CTRL);
    wr_ctrl = wr && is_reg(apb_req.paddr, OFF_OSC_CTRL);
    wr_pf2 = wr && is_reg(apb_req.paddr, OFF_PFLAG2);
    wr_pen2 = wr && is_reg(apb_req.paddr, OFF_PEN2);
    wr_irqc = wr && is_reg(apb_req.paddr, OFF_IRQ_CTRL);
    scs_new = apb_req.pwdata[SCS_LSB +: SCS_W];
    scs_chg = wr_ctrl && (scs_new != q.clock_source_select);

    rdata = '0;
    if (is_reg(apb_req.paddr, OFF_OSC_CTRL)) begin
      rdata[IFS_LSB +: IFS_W] = q.ifs;
      rdata[SCS_LSB +: SCS_W] = q.clock_source_select;
    end else if (is_reg(apb_req.paddr, OFF_OSC_STAT)) begin
      rdata[ST_OST_DONE] = ost_done;
      rdata[ST_EXT_RUN] = (q.cs == CS_EXT_RUN);
      rdata[ST_FAIL_SAFE] = (q.cs == CS_FAIL_SAFE);
      rdata[ST_MON_ON] = monitor_on;
    end else if (is_reg(apb_req.paddr, OFF_PFLAG2)) begin
      rdata[OSF_BIT] = q.osf;
    end else if (is_reg(apb_req.paddr, OFF_PEN2)) begin
      rdata[OSE_BIT] = q.ose;
    end else if (is_reg(apb_req.paddr, OFF_IRQ_CTRL)) begin
      rdata[GIE_BIT] = q.global_irq_enable;
      rdata[PERIPHERAL_IRQ_ENABLE_BIT] = q.peripheral_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ext_s1 = ext_clk_pin;
    d.ext_s2 = q.ext_s1;
    d.ext_s3 = q.ext_s2;
    d.lf_s1 = lf_osc_pin;
    d.lf_s2 = q.lf_s1;
    d.lf_s3 = q.lf_s2;
    d.sleep_q = sleep_req;

    // set wins over clear when both edges meet in one cycle
    if (ext_fall) begin
      d.fdl = 1'b1;
    end else if (samp_rise) begin
      d.fdl = 1'b0;
    end

    // timer restarts on wake and on a source change; reset value starts it too
    d.ost_go = scs_chg || sleep_exit;

    if (wr_ctrl) begin
      d.ifs = apb_req.pwdata[IFS_LSB +: IFS_W];
      d.clock_source_select = scs_new;
    end
    if (wr_pen2) begin
      d.ose = apb_req.pwdata[OSE_BIT];
    end
    if (wr_irqc) begin
      d.global_irq_enable = apb_req.pwdata[GIE_BIT];
      d.peripheral_irq_enable = apb_req.pwdata[PERIPHERAL_IRQ_ENABLE_BIT];
    end

    // hardware set wins over a software write in the same cycle
    if (fail_det) begin
      d.osf = 1'b1;
    end else if (wr_pf2) begin
      d.osf = apb_req.pwdata[OSF_BIT];
    end

    if (sleep_entry || scs_chg) begin
      d.cs = CS_INT_START;
    end else begin
      unique case (q.cs)
        CS_INT_START: begin
          if (!q.sleep_q && !q.ost_go) begin
            if (q.clock_source_select[SCS_INT_BIT]) begin
              d.cs = CS_INT_RUN;
            end else if (ost_done) begin
              d.cs = CS_EXT_RUN;
            end
          end
        end
        CS_EXT_RUN: begin
          if (fail_det) begin
            d.cs = CS_FAIL_SAFE;
          end
        end
        CS_FAIL_SAFE: begin
          d.cs = CS_FAIL_SAFE;
        end
        CS_INT_RUN: begin
          d.cs = CS_INT_RUN;
        end
      endcase
    end

    // outside the external run state the core clocks from the internal oscillator
    d.sel_int = (d.cs != CS_EXT_RUN) || !ext_mode;
    d.sel_sec = (d.clock_source_select == SCS_SECONDARY);
    d.fail_safe = (d.cs == CS_FAIL_SAFE);
    d.irq = d.osf && d.ose && d.peripheral_irq_enable && d.global_irq_enable;

    // read data is captured in the setup cycle so it is a flop in access
    if (setup) begin
      d.prdata = rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ost_go <= 1'b1;
      q.ifs <= IFS_RST;
      q.clock_source_select <= SCS_RST;
      q.cs <= CS_INT_START;
      q.sel_int <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = access && !mapped;
  assign apb_rsp.prdata = q.prdata;
  assign clk_ctrl.sel_internal = q.sel_int;
  assign clk_ctrl.sel_secondary = q.sel_sec;
  assign clk_ctrl.fail_safe = q.fail_safe;
  assign clk_ctrl.dual_speed = monitor_enable_fuse;
  assign clk_ctrl.int_freq_sel = q.ifs;
  assign osc_fail_irq = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_no_early_fail: assert property (@(posedge pclk) disable iff (!presetn)
    fail_det |-> (ost_done && q.cs == CS_EXT_RUN))
    else $error("failure reported before start-up completed");

  chk_fuse_gates_mon: assert property (@(posedge pclk) disable iff (!presetn)
    !monitor_enable_fuse |=> !$rose(q.fail_safe))
    else $error("fail-safe entered with monitor fuse clear");

  chk_latch_set_edge: assert property (@(posedge pclk) disable iff (!presetn)
    (q.ext_s3 && !q.ext_s2) |=> q.fdl)
    else $error("falling external edge did not set the latch");

  chk_latch_clear_samp: assert property (@(posedge pclk) disable iff (!presetn)
    (samp_rise && !ext_fall) |=> !q.fdl)
    else $error("sample rising edge did not clear the latch");

  chk_fail_switch_flag: assert property (@(posedge pclk) disable iff (!presetn)
    (fail_det && !scs_chg && !sleep_entry) |=>
      (q.cs == CS_FAIL_SAFE && q.osf && q.sel_int && q.fail_safe))
    else $error("failure did not switch clock and set flag");

  chk_irq_all_enables: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(osc_fail_irq) |-> ($past(q.global_irq_enable) || q.global_irq_enable) && q.peripheral_irq_enable && q.ose && q.osf)
    else $error("interrupt raised without all enables");

  chk_failsafe_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (q.cs == CS_FAIL_SAFE && !scs_chg && !sleep_entry) |=> q.cs == CS_FAIL_SAFE)
    else $error("fail-safe left without software action");

  chk_scs_restart: assert property (@(posedge pclk) disable iff (!presetn)
    scs_chg |=> (q.cs == CS_INT_START && q.sel_int && q.ost_go))
    else $error("source change did not restart start-up");

  chk_flag_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    (fail_det && wr_pf2) |=> q.osf)
    else $error("software clear beat a hardware failure");

endmodule

// ---- verif/clock_fail_monitor_ext_osc.sv ----
`timescale 1ns/100ps
// stand-in for the external oscillator; once stopped it finishes the period in progress, then parks low with no more edges
module clock_fail_monitor_ext_osc (
  input wire logic run,
  input wire logic [7:0] half_ns,
  output logic osc
);
  initial begin
    osc = 1'b0;
    forever begin
      wait (run);
      #(half_ns) osc = 1'b1;
      #(half_ns) osc = 1'b0;
    end
  end
endmodule

// ---- verif/test_fail_safe_clock_monitor.sv ----
`timescale 1ns/100ps
module test_fail_safe_clock_monitor
  import clock_fail_monitor_pkg::*;
;
  localparam int B_INT = 7;
  localparam int B_FS = 5;
  logic pclk, presetn, ext_run, lf, fuse, sleep_req, irq, ext_clk;
  logic [7:0] ext_half;
  clock_fail_monitor_osc_mode_t mode;
  clock_fail_monitor_apb_req_t req;
  clock_fail_monitor_apb_rsp_t rsp;
  clock_fail_monitor_clk_ctrl_t ctl;
  int checks = 0;
  int n_fail = 0;

  clock_fail_monitor_ext_osc clock_fail_monitor_ext_osc_i (.run(ext_run), .half_ns(ext_half), .osc(ext_clk));
  clock_fail_monitor_top #(.OST_COUNT(4), .DIV(4)) clock_fail_monitor_top_i (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .ext_clk_pin(ext_clk), .lf_osc_pin(lf), .monitor_enable_fuse(fuse),
    .osc_mode(mode), .sleep_req(sleep_req), .clk_ctrl(ctl), .osc_fail_irq(irq)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // low-frequency oscillator; sample half period is 2 of its periods (about 161 ns)
  initial begin
    lf = 1'b0;
    forever #40.3 lf = ~lf;
  end

  // ------
  // helpers
  // ------
  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    @(posedge pclk);
    while (rsp.pready !== 1'b1) @(posedge pclk);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic err;
    xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic eerr,
                        input string what);
    logic [31:0] rd;
    logic err;
    xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, what);
    chk(32'(err), 32'(eerr), what);
  endtask

  task automatic wait_bit(input int b, input logic v, input int lim, input string what);
    int n = 0;
    while (ctl[b] !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(ctl[b]), 32'(v), what);
  endtask

  // watches that a control bit never leaves its value over a span
  task automatic hold_bit(input int b, input logic v, input int cyc, input string what);
    logic ok = 1'b1;
    repeat (cyc) begin
      @(posedge pclk);
      if (ctl[b] !== v) ok = 1'b0;
    end
    chk(32'(ok), 32'h1, what);
  endtask

  task automatic do_reset(input logic f, input clock_fail_monitor_osc_mode_t m);
    @(posedge pclk);
    presetn <= 1'b0;
    fuse <= f;
    mode <= m;
    sleep_req <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // ------
  // scenarios
  // ------
  task automatic t_reset_vals();
    chk(32'(ctl), 32'h97, "ctl rst");
    chk(32'(irq), 32'h0, "irq rst");
    rd_chk(OFF_OSC_CTRL, 32'h07, 1'b0, "ctrl rst");
    rd_chk(8'h14, 32'h0, 1'b1, "unmapped");
  endtask

  // external clock dead from reset: timer never ends, nothing is reported
  task automatic t_no_early();
    hold_bit(B_FS, 1'b0, 300, "early fail");
    chk(32'(ctl.sel_internal), 32'h1, "early int");
    rd_chk(OFF_OSC_STAT, 32'h0, 1'b0, "early stat");
  endtask

  // falls every 90 ns, inside a 161 ns sample half period: never a failure
  task automatic t_slow_ok();
    ext_half = 8'd45;
    ext_run = 1'b1;
    wait_bit(B_INT, 1'b0, 200, "to ext");
    rd_chk(OFF_OSC_STAT, 32'h0b, 1'b0, "stat run");
    hold_bit(B_FS, 1'b0, 300, "slow ok");
  endtask

  task automatic t_fail_irq();
    wr(OFF_OSC_CTRL, 32'h0b);
    ext_run = 1'b0;
    wait_bit(B_FS, 1'b1, 300, "fail");
    chk(32'(ctl.sel_internal), 32'h1, "fail int");
    chk(32'(ctl.int_freq_sel), 32'hb, "fallback");
    rd_chk(OFF_PFLAG2, 32'h80, 1'b0, "flag");
    wr(OFF_PEN2, 32'h80);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq no gie");
    wr(OFF_IRQ_CTRL, 32'hc0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h1, "irq on");
    wr(OFF_IRQ_CTRL, 32'h80);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq no peripheral_irq_enable");
    wr(OFF_IRQ_CTRL, 32'hc0);
    hold_bit(B_INT, 1'b1, 100, "stay int");
  endtask

  task automatic t_recover();
    ext_half = 8'd20;
    ext_run = 1'b1;
    wr(OFF_PFLAG2, 32'h0);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "flag clr");
    wr(OFF_OSC_CTRL, 32'h1b);
    wait_bit(B_FS, 1'b0, 3, "scs clr");
    chk(32'(ctl.sel_internal), 32'h1, "ost int");
    chk(32'(ctl.sel_secondary), 32'h1, "sec sel");
    wait_bit(B_INT, 1'b0, 200, "back ext");
    rd_chk(OFF_OSC_STAT, 32'h0b, 1'b0, "stat back");
  endtask

  task automatic t_sleep();
    ext_run = 1'b0;
    wait_bit(B_FS, 1'b1, 300, "fail 2");
    sleep_req <= 1'b1;
    wait_bit(B_FS, 1'b0, 3, "sleep clr");
    ext_run = 1'b1;
    repeat (4) @(posedge pclk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(OFF_OSC_STAT, 32'h0, 1'b0, "wake ost");
    wait_bit(B_INT, 1'b0, 200, "wake ext");
  endtask

  task automatic t_modes();
    clock_fail_monitor_osc_mode_t m;
    logic byp;
    for (int i = 0; i < 6; i++) begin
      m = clock_fail_monitor_osc_mode_t'(3'(i));
      byp = (m == OSC_EXTERNAL_CLOCK_INPUT) || (m == OSC_RESISTOR_CAPACITOR);
      ext_run = !byp;
      do_reset(1'b1, m);
      wait_bit(B_INT, 1'b0, byp ? 12 : 200, "start");
      ext_run = 1'b0;
      wait_bit(B_FS, 1'b1, 300, "mode fail");
    end
  endtask

  // without the fuse the switch sequencing still runs but detection is off
  task automatic t_fuse_off();
    ext_run = 1'b1;
    do_reset(1'b0, OSC_CRYSTAL);
    wait_bit(B_INT, 1'b0, 200, "nf ext");
    chk(32'(ctl.dual_speed), 32'h0, "no dual");
    ext_run = 1'b0;
    hold_bit(B_FS, 1'b0, 300, "no fuse");
    // internal mode is never monitored and never leaves the internal clock
    ext_run = 1'b1;
    do_reset(1'b1, OSC_INTERNAL);
    hold_bit(B_INT, 1'b1, 150, "int mode");
    ext_run = 1'b0;
    hold_bit(B_FS, 1'b0, 300, "int no mon");
  endtask

  initial begin
    presetn = 1'b0;
    ext_run = 1'b0;
    ext_half = 8'd20;
    fuse = 1'b1;
    mode = OSC_CRYSTAL;
    sleep_req = 1'b0;
    req = '0;
    do_reset(1'b1, OSC_CRYSTAL);
    t_reset_vals();
    t_no_early();
    t_slow_ok();
    t_fail_irq();
    t_recover();
    t_sleep();
    t_modes();
    t_fuse_off();
    close_out();
  end

  // the sequence needs under 10000 cycles
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    close_out();
  end
endmodule
